//--- hw/fsps_sequencer.sv
// fsps_sequencer: flash self-programming sequencer with its own flash array
// assumes core strobes are one-cycle pulses on CLK, ptr and data held stable
//
// Contract
// [RULE1] no-op command: load instruction returns addressed flash byte at once
// [RULE2] buffer erase by execute bit clears buffer, busy until done
// [RULE3] load-buffer store writes word at pointer word address, unprotected
// [RULE4] buffer words not loaded since clear commit as all ones
// [RULE5] flash page erase uses only the page field, busy until done
// [RULE6] section busy during page erase or write, application reads blocked
// [RULE7] page write programs buffer into pointer page, busy until done
// [RULE8] range crc uses address and data registers, busy, halt, result
// [RULE9] range crc runs only with no boot lock bits, else aborts
// [RULE10] application erase wipes whole section when pointer is inside it
// [RULE11] application and boot page erase hit one page in their section
// [RULE12] invalid or wrong-section page aborts section erase and write
// [RULE13] erase-and-write erases then programs as one uninterrupted run
// [RULE14] section crc commands busy, halt and leave checksum in data
// [RULE15] signature row erase by store, busy and halt until done
// [RULE16] signature row cannot be read while it is written
// [RULE17] signature row write programs buffer, halt and busy meanwhile
// [RULE18] after signature write the buffer clears with core running
// [RULE19] software opens change protection before each protected trigger
// [RULE20] target address latched at start, pointer free afterwards
// [RULE21] codes 0x23 load buffer and 0x26 erase buffer
// [RULE22] codes 0x2b page erase, 0x2f erase-write, 0x2e page write
// [RULE23] codes 0x3a range crc, 0x38 application crc, 0x39 boot crc
// [RULE24] triggers ignored while busy; busy drops on finish or abort
`timescale 1ns/100ps
`default_nettype none
module fsps_sequencer
    import fsps_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [6:0] CMD,
    input wire logic CMD_EXEC,
    input wire logic PM_STORE,
    input wire logic PM_LOAD,
    input wire logic [15:0] PTR,
    input wire logic [15:0] STORE_WORD,
    input wire logic [15:0] NVM_ADDR,
    input wire logic [15:0] NVM_DATA,
    input wire logic CHG_PROT_OPEN,
    input wire logic [1:0] BOOT_LOCK,
    output logic BUSY,
    output logic SECTION_BUSY,
    output logic CPU_HALT,
    output logic ABORTED,
    output logic [7:0] LOAD_BYTE,
    output logic [15:0] CRC_DATA
);
    fsps_state_t state_ff, nxt_state, op_st;
    logic [8:0] idx_ff, nxt_idx, lo_ff, hi_ff, op_lo, op_hi, pg_lo, pg_hi;
    logic prog_ff, sig_ff, busy_ff, flash_section_busy_flag_ff, halt_ff, abort_ff;
    logic op_prog, op_sig, op_halt, op_bad, op_x;
    logic trig, take, start, fail, in_boot, ptr_bad, buf_wr, buf_clr;
    logic [15:0] mem [MEM_WORDS];
    logic [15:0] buf_q, crc_ff, crc_out_ff, crc_word, rd_word;
    logic [7:0] rd_byte, load_byte_ff;

    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        return r;
    endfunction

    // page field only; byte and word bits of the pointer are dropped
    assign pg_lo = {1'b0, PTR[8:4], 3'h0}; // [RULE5]
    assign pg_hi = {1'b0, PTR[8:4], 3'h7};
    assign in_boot = PTR[8:4] >= APP_PAGES;
    assign ptr_bad = |PTR[15:9];

    // command decode: target range, phases, halt and validity
    always_comb
    begin
        op_st = ST_IDLE;
        op_lo = pg_lo;
        op_hi = pg_hi;
        op_prog = 1'b0;
        op_sig = 1'b0;
        op_halt = 1'b0;
        op_bad = ptr_bad;
        op_x = 1'b0;
        case (CMD)
            CMD_ERASE_BUF: // [RULE21]
            begin
                op_st = ST_BCLR; // [RULE2]
                op_lo = 9'h000;
                op_bad = 1'b0;
                op_x = 1'b1;
            end
            CMD_FL_PG_ER: // [RULE22]
            begin
                op_st = ST_ERASE; // [RULE5]
                op_halt = in_boot;
            end
            CMD_FL_PG_WR: // [RULE22]
            begin
                op_st = ST_PROG; // [RULE7]
                op_halt = in_boot;
            end
            CMD_FL_PG_EW: // [RULE22]
            begin
                op_st = ST_ERASE; // [RULE13]
                op_prog = 1'b1;
                op_halt = in_boot;
            end
            CMD_APP_ERASE:
            begin
                op_st = ST_ERASE; // [RULE10]
                op_lo = 9'h000;
                op_hi = APP_LAST_W;
                op_halt = 1'b1;
                op_bad = ptr_bad || in_boot;
            end
            CMD_APP_PG_ER, CMD_APP_PG_WR, CMD_APP_PG_EW:
            begin
                op_st = (CMD == CMD_APP_PG_WR) ? ST_PROG : ST_ERASE; // [RULE11]
                op_prog = (CMD == CMD_APP_PG_EW); // [RULE13]
                op_bad = ptr_bad || in_boot; // [RULE12]
            end
            CMD_BOOT_PG_ER, CMD_BOOT_PG_WR, CMD_BOOT_PG_EW:
            begin
                op_st = (CMD == CMD_BOOT_PG_WR) ? ST_PROG : ST_ERASE; // [RULE11]
                op_prog = (CMD == CMD_BOOT_PG_EW); // [RULE13]
                op_halt = 1'b1;
                op_bad = ptr_bad || !in_boot; // [RULE12]
            end
            CMD_SIG_ERASE, CMD_SIG_WRITE:
            begin
                // [RULE15] [RULE17]
                op_st = (CMD == CMD_SIG_WRITE) ? ST_PROG : ST_ERASE;
                op_sig = (CMD == CMD_SIG_WRITE); // [RULE18]
                op_lo = SIG_FIRST_W;
                op_hi = SIG_LAST_W;
                op_halt = 1'b1; // [RULE16]
                op_bad = 1'b0;
            end
            CMD_CRC_RANGE: // [RULE23]
            begin
                op_st = ST_CRC; // [RULE8]
                op_lo = {1'b0, NVM_ADDR[8:1]};
                op_hi = {1'b0, NVM_DATA[8:1]};
                op_halt = 1'b1;
                op_x = 1'b1;
                // locks cover the whole flash here, so any lock refuses
                op_bad = (BOOT_LOCK != 2'h0) || |NVM_ADDR[15:9] || // [RULE9]
                         |NVM_DATA[15:9] || (NVM_ADDR[8:1] > NVM_DATA[8:1]);
            end
            CMD_CRC_APP, CMD_CRC_BOOT: // [RULE23]
            begin
                op_st = ST_CRC; // [RULE14]
                op_lo = (CMD == CMD_CRC_APP) ? 9'h000 : BOOT_FIRST_W;
                op_hi = (CMD == CMD_CRC_APP) ? APP_LAST_W : BOOT_LAST_W;
                op_halt = 1'b1;
                op_bad = 1'b0;
                op_x = 1'b1;
            end
            default: ;
        endcase
    end

    // protected triggers need the open window and an idle sequencer
    assign trig = (op_st != ST_IDLE) && (op_x ? CMD_EXEC : PM_STORE);
    assign take = trig && !busy_ff && CHG_PROT_OPEN; // [RULE19] [RULE24]
    assign start = take && !op_bad;
    assign fail = take && op_bad; // [RULE12]

    // sequence stepping: one word per cycle through the latched range, buffer clear counts 0 to BUF_CLR_LAST
    always_comb
    begin
        nxt_state = state_ff;
        nxt_idx = idx_ff + 9'h001;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_idx = idx_ff;
                if (start)
                begin
                    nxt_state = op_st;
                    nxt_idx = op_lo;
                end
            end
            ST_ERASE:
                if (idx_ff == hi_ff)
                begin
                    // erase flows straight into programming, no gap
                    nxt_state = prog_ff ? ST_PROG : ST_IDLE; // [RULE13]
                    nxt_idx = lo_ff;
                end
            ST_PROG:
                if (idx_ff == hi_ff)
                begin
                    nxt_state = sig_ff ? ST_BCLR : ST_IDLE; // [RULE18]
                    nxt_idx = 9'h000;
                end
            ST_BCLR:
                if (idx_ff == BUF_CLR_LAST)
                    nxt_state = ST_IDLE; // [RULE2]
            ST_CRC:
                if (idx_ff == hi_ff)
                    nxt_state = ST_IDLE; // [RULE14]
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_ff <= ST_IDLE;
            idx_ff <= 9'h000;
        end
        else
        begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
        end
    end

    // target latched at start so the pointer may be reused
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            lo_ff <= 9'h000;
            hi_ff <= 9'h000;
            prog_ff <= 1'b0;
            sig_ff <= 1'b0;
        end
        else if (start)
        begin
            lo_ff <= op_lo; // [RULE20]
            hi_ff <= op_hi;
            prog_ff <= op_prog;
            sig_ff <= op_sig;
        end
    end

    // busy, section busy and halt follow the next state so they line up with it; abort follows the trigger
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            busy_ff <= 1'b0;
            flash_section_busy_flag_ff <= 1'b0;
            halt_ff <= 1'b0;
            abort_ff <= 1'b0;
        end
        else
        begin
            busy_ff <= nxt_state != ST_IDLE; // [RULE24]
            flash_section_busy_flag_ff <= nxt_state == ST_ERASE || nxt_state == ST_PROG; // [RULE6]
            if (start)
                halt_ff <= op_halt;
            else if (nxt_state == ST_IDLE || nxt_state == ST_BCLR)
                halt_ff <= 1'b0; // [RULE18]
            if (fail)
                abort_ff <= 1'b1;
            else if (start)
                abort_ff <= 1'b0;
        end
    end

    // flash array: nonvolatile, so it has no reset
    always_ff @(posedge CLK)
    begin
        if (state_ff == ST_ERASE)
            mem[idx_ff] <= WORD_ONES;
        else if (state_ff == ST_PROG)
            mem[idx_ff] <= buf_q; // [RULE7] [RULE17]
    end

    assign buf_wr = PM_STORE && CMD == CMD_LOAD_BUF && !busy_ff; // [RULE3]
    assign buf_clr = state_ff == ST_BCLR && idx_ff == 9'h000; // [RULE2]

    fsps_page_buf u_buf (
        .clk(CLK),
        .rst_n(RESETN),
        .wr_en(buf_wr),
        .wr_idx(PTR[3:1]),
        .wr_data(STORE_WORD),
        .clr(buf_clr),
        .rd_idx(idx_ff[2:0]),
        .rd_data(buf_q)
    );

    // crc over each word, low byte first
    assign crc_word = crc_byte(crc_byte(crc_ff, mem[idx_ff][7:0]),
                               mem[idx_ff][15:8]);

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            crc_ff <= CRC_INIT;
            crc_out_ff <= 16'h0000;
        end
        else if (start && op_st == ST_CRC)
            crc_ff <= CRC_INIT;
        else if (state_ff == ST_CRC)
        begin
            crc_ff <= crc_word;
            if (idx_ff == hi_ff)
                crc_out_ff <= crc_word; // [RULE8] [RULE14]
        end
    end

    // byte read; application words refused while a section is written, every word during a signature write
    assign rd_word = mem[{1'b0, PTR[8:1]}];
    assign rd_byte = PTR[0] ? rd_word[15:8] : rd_word[7:0];

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            load_byte_ff <= 8'h00;
        else if (PM_LOAD && CMD == CMD_NOOP)
        begin
            if (ptr_bad || (flash_section_busy_flag_ff && (sig_ff || !in_boot))) // [RULE6] [RULE16]
                load_byte_ff <= 8'hff;
            else
                load_byte_ff <= rd_byte; // [RULE1]
        end
    end

    assign BUSY = busy_ff;
    assign SECTION_BUSY = flash_section_busy_flag_ff;
    assign CPU_HALT = halt_ff;
    assign ABORTED = abort_ff;
    assign LOAD_BYTE = load_byte_ff;
    assign CRC_DATA = crc_out_ff;

    sequence s_ew_handoff;
        state_ff == ST_ERASE && prog_ff && idx_ff == hi_ff;
    endsequence

    sequence s_prog_run;
        state_ff == ST_PROG && idx_ff == lo_ff;
    endsequence

    lpm_read_a: assert property ( // [RULE1]
        @(posedge CLK) disable iff (!RESETN)
        (PM_LOAD && CMD == CMD_NOOP && !flash_section_busy_flag_ff && !ptr_bad)
        |=> (LOAD_BYTE == $past(rd_byte)))
    else $error("load instruction byte mismatch");

    buf_clear_busy_a: assert property ( // [RULE2]
        @(posedge CLK) disable iff (!RESETN)
        (start && CMD == CMD_ERASE_BUF) |=> BUSY [*8] ##1 !BUSY)
    else $error("buffer erase busy length wrong");

    load_free_a: assert property ( // [RULE3]
        @(posedge CLK) disable iff (!RESETN)
        (PM_STORE && CMD == CMD_LOAD_BUF && !BUSY && !CHG_PROT_OPEN)
        |=> !BUSY && !ABORTED == !$past(ABORTED))
    else $error("buffer load disturbed status");

    section_busy_a: assert property ( // [RULE6]
        @(posedge CLK) disable iff (!RESETN)
        (state_ff == ST_ERASE || state_ff == ST_PROG)
        |-> SECTION_BUSY && BUSY)
    else $error("section busy missing during erase or write");

    crc_halt_a: assert property ( // [RULE8]
        @(posedge CLK) disable iff (!RESETN)
        (start && op_st == ST_CRC) |=> BUSY && CPU_HALT)
    else $error("crc not busy or not halted");

    lock_abort_a: assert property ( // [RULE9]
        @(posedge CLK) disable iff (!RESETN)
        (take && CMD == CMD_CRC_RANGE && BOOT_LOCK != 2'h0)
        |=> ABORTED && !BUSY)
    else $error("locked range crc not aborted");

    wrong_section_a: assert property ( // [RULE12]
        @(posedge CLK) disable iff (!RESETN)
        (take && CMD == CMD_APP_PG_ER && in_boot) |=> ABORTED && !BUSY)
    else $error("wrong section page erase not aborted");

    erase_then_prog_a: assert property ( // [RULE13]
        @(posedge CLK) disable iff (!RESETN)
        s_ew_handoff |=> s_prog_run)
    else $error("erase did not pass straight to write");

    sig_clear_run_a: assert property ( // [RULE18]
        @(posedge CLK) disable iff (!RESETN)
        (state_ff == ST_PROG && sig_ff && idx_ff == hi_ff)
        |=> (state_ff == ST_BCLR && !CPU_HALT && BUSY))
    else $error("signature buffer clear stage wrong");

    latch_stable_a: assert property ( // [RULE20]
        @(posedge CLK) disable iff (!RESETN)
        (BUSY && $past(BUSY)) |-> $stable(hi_ff) && $stable(lo_ff))
    else $error("latched target moved during operation");
endmodule
`default_nettype wire

//--- hw/fsps_pkg.sv
// fsps_pkg: constants, command codes and states of the self-program sequencer
// assumes a 16-bit word flash of 32 pages of 8 words plus one signature row
package fsps_pkg;
    localparam int CLK_NS = 4;
    localparam int T_BUFCLR_NS = 32;
    // page buffer clear time in whole cycles, at least one
    localparam int BUF_CLR_CYC = (T_BUFCLR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [8:0] BUF_CLR_LAST = 9'(BUF_CLR_CYC - 1);
    localparam int PAGE_WORDS = 8;
    localparam logic [15:0] WORD_ONES = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    // word index layout of the array: application, boot, signature row
    localparam logic [4:0] APP_PAGES = 5'h18;
    localparam logic [8:0] APP_LAST_W = 9'h0bf;
    localparam logic [8:0] BOOT_FIRST_W = 9'h0c0;
    localparam logic [8:0] BOOT_LAST_W = 9'h0ff;
    localparam logic [8:0] SIG_FIRST_W = 9'h100;
    localparam logic [8:0] SIG_LAST_W = 9'h107;
    localparam int MEM_WORDS = 264;
    // command select codes
    localparam logic [6:0] CMD_NOOP = 7'h00;
    localparam logic [6:0] CMD_SIG_ERASE = 7'h18;
    localparam logic [6:0] CMD_SIG_WRITE = 7'h1a;
    localparam logic [6:0] CMD_APP_ERASE = 7'h20;
    localparam logic [6:0] CMD_APP_PG_ER = 7'h22;
    localparam logic [6:0] CMD_LOAD_BUF = 7'h23;
    localparam logic [6:0] CMD_APP_PG_WR = 7'h24;
    localparam logic [6:0] CMD_APP_PG_EW = 7'h25;
    localparam logic [6:0] CMD_ERASE_BUF = 7'h26;
    localparam logic [6:0] CMD_BOOT_PG_ER = 7'h2a;
    localparam logic [6:0] CMD_FL_PG_ER = 7'h2b;
    localparam logic [6:0] CMD_BOOT_PG_WR = 7'h2c;
    localparam logic [6:0] CMD_BOOT_PG_EW = 7'h2d;
    localparam logic [6:0] CMD_FL_PG_WR = 7'h2e;
    localparam logic [6:0] CMD_FL_PG_EW = 7'h2f;
    localparam logic [6:0] CMD_CRC_APP = 7'h38;
    localparam logic [6:0] CMD_CRC_BOOT = 7'h39;
    localparam logic [6:0] CMD_CRC_RANGE = 7'h3a;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_ERASE = 3'h1,
        ST_PROG = 3'h3,
        ST_BCLR = 3'h2,
        ST_CRC = 3'h6
    } fsps_state_t;
endpackage

//--- hw/fsps_page_buf.sv
// fsps_page_buf: one flash page of write buffer with a loaded mark per word
// assumes the sequencer never clears and loads in the same cycle
`timescale 1ns/100ps
`default_nettype none
module fsps_page_buf
    import fsps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic clr,
    input wire logic [2:0] rd_idx,
    output logic [15:0] rd_data
);
    logic [15:0] ent_q [PAGE_WORDS];

    genvar g;
    for (g = 0; g < PAGE_WORDS; g++)
    begin : g_ent
        logic loaded_ff;
        logic [15:0] word_ff;
        // clear only drops the marks, so it costs a single cycle
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                loaded_ff <= 1'b0;
            else if (clr)
                loaded_ff <= 1'b0;
            else if (wr_en && wr_idx == 3'(g))
                loaded_ff <= 1'b1;
        end
        always_ff @(posedge clk)
        begin
            if (wr_en && wr_idx == 3'(g))
                word_ff <= wr_data;
        end
        // words not loaded since the last clear read as all ones
        assign ent_q[g] = loaded_ff ? word_ff : WORD_ONES; // [RULE4]
    end

    assign rd_data = ent_q[rd_idx];

    unloaded_ones_a: assert property ( // [RULE4]
        @(posedge clk) disable iff (!rst_n)
        (clr && !wr_en) |=> (rd_data == WORD_ONES))
    else $error("unloaded buffer word is not all ones");
endmodule
`default_nettype wire

//--- tb/fsps_core_model.sv
// fsps_core_model: processor core side that issues self-program triggers
// assumes its tasks are called from the bench at falling clock edges
`timescale 1ns/100ps
`default_nettype none
module fsps_core_model
(
    input wire logic clk,
    output logic [6:0] cmd,
    output logic cmd_exec,
    output logic pm_store,
    output logic pm_load,
    output logic [15:0] ptr,
    output logic [15:0] store_word,
    output logic [15:0] nvm_addr,
    output logic [15:0] nvm_data,
    output logic chg_prot_open,
    output logic [1:0] boot_lock
);
    // idle levels from time zero, no strobe pending
    initial
    begin
        cmd = 7'h00;
        {cmd_exec, pm_store, pm_load, chg_prot_open} = 4'h0;
        {ptr, store_word, nvm_addr, nvm_data} = 64'h0;
        boot_lock = 2'h0;
    end

    // range bounds and lock level as software leaves them
    task automatic set_range(input logic [15:0] a, input logic [15:0] d,
        input logic [1:0] lk);
        nvm_addr = a;
        nvm_data = d;
        boot_lock = lk;
    endtask

    // one trigger pulse across a single rising edge
    task automatic issue(input logic [6:0] c, input logic ex,
        input logic [15:0] p, input logic [15:0] w, input logic prot);
        @(negedge clk);
        cmd = c;
        ptr = p;
        store_word = w;
        chg_prot_open = prot;
        cmd_exec = ex;
        pm_store = ~ex;
        @(negedge clk);
        {cmd_exec, pm_store, chg_prot_open} = 3'h0;
        // software reuses the pointer at once, so stale values never linger
        ptr = ~p;
        store_word = ~w;
    endtask

    // one load instruction with the no-op command selected
    task automatic load(input logic [15:0] p);
        @(negedge clk);
        cmd = 7'h00;
        ptr = p;
        pm_load = 1'b1;
        @(negedge clk);
        pm_load = 1'b0;
        ptr = ~p;
    endtask
endmodule
`default_nettype wire

//--- tb/fsps_sequencer_tb.sv
// fsps_sequencer_tb: self-checking bench with a word model of the array
// assumes the core model drives every sequencer input but CLK and RESETN
`timescale 1ns/100ps
`default_nettype none
module fsps_sequencer_tb
    import fsps_pkg::*;
;
    logic CLK, RESETN;
    logic [6:0] cmd;
    logic cmd_exec, pm_store, pm_load, chg_prot_open;
    logic [15:0] ptr, store_word, nvm_addr, nvm_data;
    logic [1:0] boot_lock;
    logic BUSY, SECTION_BUSY, CPU_HALT, ABORTED;
    logic [7:0] LOAD_BYTE;
    logic [15:0] CRC_DATA;
    int mem[MEM_WORDS];
    int pbuf[PAGE_WORDS];
    int errors = 0;
    int n_tests = 0;
    int nb, nh, ns;

    fsps_core_model core (.clk(CLK), .cmd(cmd), .cmd_exec(cmd_exec),
        .pm_store(pm_store), .pm_load(pm_load), .ptr(ptr),
        .store_word(store_word), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
        .chg_prot_open(chg_prot_open), .boot_lock(boot_lock));

    fsps_sequencer DUT (.CLK(CLK), .RESETN(RESETN), .CMD(cmd),
        .CMD_EXEC(cmd_exec), .PM_STORE(pm_store), .PM_LOAD(pm_load),
        .PTR(ptr), .STORE_WORD(store_word), .NVM_ADDR(nvm_addr),
        .NVM_DATA(nvm_data), .CHG_PROT_OPEN(chg_prot_open),
        .BOOT_LOCK(boot_lock), .BUSY(BUSY), .SECTION_BUSY(SECTION_BUSY),
        .CPU_HALT(CPU_HALT), .ABORTED(ABORTED), .LOAD_BYTE(LOAD_BYTE),
        .CRC_DATA(CRC_DATA));

    // 250 MHz clock
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    task automatic conclude();
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask

    // pointer to a page with random word and byte bits below the page field
    function automatic logic [15:0] pp(input int p);
        return 16'(p * 16) | 16'($urandom & 'hf);
    endfunction

    // model: erase to all ones, or program from the page buffer
    function automatic void fill(input int first, input int n, input bit prog);
        for (int i = 0; i < n; i++)
            mem[first + i] = prog ? pbuf[i % PAGE_WORDS] : 'hffff;
    endfunction

    // bytewise checksum, low byte first, msb-first shifting
    function automatic int crc_of(input int first, input int last);
        int c = 'hffff;
        for (int w = first; w <= last; w++)
            for (int b = 0; b < 16; b += 8)
            begin
                c ^= ((mem[w] >> b) & 'hff) << 8;
                for (int k = 0; k < 8; k++)
                    c = ((c << 1) ^ ((c & 'h8000) ? 'h1021 : 0)) & 'hffff;
            end
        return c;
    endfunction

    // read both bytes of one word through load instructions
    task automatic rd(input int w);
        for (int b = 0; b < 2; b++)
        begin
            core.load(16'(w * 2 + b));
            check("rd byte", LOAD_BYTE, (mem[w] >> 8 * b) & 'hff);
        end
    endtask

    // protected trigger, then count busy, halt and section busy cycles
    task automatic run(input logic [6:0] c, input logic ex,
        input logic [15:0] p, input int eb, input int eh, input int es,
        input logic ab);
        int guard;
        nb = 0;
        nh = 0;
        ns = 0;
        core.issue(c, ex, p, 16'h0000, 1'b1);
        for (guard = 0; guard < 2000 && BUSY === 1'b1; guard++)
        begin
            nb++;
            nh += (CPU_HALT === 1'b1);
            ns += (SECTION_BUSY === 1'b1);
            @(negedge CLK);
        end
        check("busy cycles", nb, eb);
        check("halt cycles", nh, eh);
        check("section busy cycles", ns, es);
        check("aborted", ABORTED, ab);
    endtask

    // main sequence
    initial
    begin
        int s, e, n;
        void'($urandom(6353));
        RESETN = 1'b0;
        foreach (pbuf[i]) pbuf[i] = 'hffff;
        repeat (12) @(posedge CLK);
        @(negedge CLK);
        RESETN = 1'b1;
        check("reset busy", {BUSY, SECTION_BUSY}, 0);
        check("reset halt", {CPU_HALT, ABORTED}, 0);
        check("reset data", {LOAD_BYTE, CRC_DATA}, 0);
        s = $urandom_range(23);
        run(CMD_APP_ERASE, 0, pp(s), 192, 192, 192, 0);
        fill(0, 192, 0);
        for (int p = 24; p < 32; p++)
        begin
            run(CMD_BOOT_PG_ER, 0, pp(p), 8, 8, 8, 0);
            fill(p * 8, 8, 0);
        end
        run(CMD_ERASE_BUF, 1, 16'h0000, 8, 0, 0, 0);
        // sparse load leaves five words at all ones
        for (int i = 0; i < 8; i += 3)
        begin
            pbuf[i] = $urandom & 'hffff;
            core.issue(CMD_LOAD_BUF, 0, 16'(48 + 2 * i),
                16'(pbuf[i]), 0);
        end
        run(CMD_FL_PG_EW, 0, pp(3), 16, 0, 16, 0);
        fill(24, 8, 1);
        for (int w = 24; w < 32; w++)
            rd(w);
        run(CMD_APP_PG_WR, 0, pp(5), 8, 0, 8, 0);
        fill(40, 8, 1);
        rd(40);
        run(CMD_APP_PG_EW, 0, pp(4), 16, 0, 16, 0);
        fill(32, 8, 1);
        rd(38);
        // read and second trigger while an application page erases
        core.issue(CMD_FL_PG_ER, 0, pp(5), 16'h0000, 1);
        core.load(16'd48);
        check("blocked read", LOAD_BYTE, 'hff);
        core.issue(CMD_FL_PG_ER, 0, pp(3), 16'h0000, 1);
        for (int g = 0; g < 50 && BUSY !== 1'b0; g++)
            @(negedge CLK);
        fill(40, 8, 0);
        rd(24);
        rd(43);
        // wrong section both ways, bad pointer, then an unprotected trigger
        run(CMD_BOOT_PG_ER, 0, pp(2), 0, 0, 0, 1);
        run(CMD_APP_PG_ER, 0, pp(26), 0, 0, 0, 1);
        run(CMD_APP_PG_ER, 0, 16'h8000 | pp(6), 0, 0, 0, 1);
        core.issue(CMD_APP_PG_ER, 0, pp(6), 16'h0000, 0);
        check("unprotected trigger", {BUSY, ABORTED}, 2'b01);
        run(CMD_APP_PG_ER, 0, pp(6), 8, 0, 8, 0);
        fill(48, 8, 0);
        s = $urandom_range(190);
        e = s + $urandom_range(40);
        n = e - s + 1;
        core.set_range(16'(s * 2), 16'(e * 2 + 1), 2'b01);
        run(CMD_CRC_RANGE, 1, 16'h0000, 0, 0, 0, 1);
        core.set_range(16'(s * 2), 16'(e * 2 + 1), 2'b00);
        run(CMD_CRC_RANGE, 1, 16'h0000, n, n, 0, 0);
        check("range checksum", CRC_DATA, crc_of(s, e));
        run(CMD_CRC_APP, 1, 16'h0000, 192, 192, 0, 0);
        check("application checksum", CRC_DATA, crc_of(0, 191));
        run(CMD_BOOT_PG_EW, 0, pp(24), 16, 16, 16, 0);
        fill(192, 8, 1);
        run(CMD_BOOT_PG_WR, 0, pp(25), 8, 8, 8, 0);
        fill(200, 8, 1);
        rd(203);
        run(CMD_CRC_BOOT, 1, 16'h0000, 64, 64, 0, 0);
        check("boot checksum", CRC_DATA, crc_of(192, 255));
        run(CMD_SIG_ERASE, 0, 16'h0000, 8, 8, 8, 0);
        run(CMD_SIG_WRITE, 0, 16'h0000, 16, 8, 8, 0);
        // the signature write must have left the buffer at all ones
        foreach (pbuf[i]) pbuf[i] = 'hffff;
        run(CMD_FL_PG_WR, 0, pp(7), 8, 0, 8, 0);
        fill(56, 8, 1);
        rd(56);
        conclude();
    end

    // watchdog at 20000 cycles, far beyond the roughly 800 cycles the sequence needs
    initial
    begin
        #(4 * 20000);
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
